// ===== src/ccpr_pkg.sv
// constants, types and decode helpers of the charger control register block
package ccpr_pkg;

	localparam logic [7:0] CTRL_OFFSET = 8'h17;
	localparam logic [7:0] PIN_OFFSET  = 8'h18;
	localparam logic [7:0] CTRL_RESET  = 8'hC9;
	localparam logic [7:0] PIN_RESET   = 8'hC0;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;

	// auto-recharge threshold codes, fraction of feedback_regulation_voltage
	localparam logic [1:0] RECHG_930_PML = 2'h0;
	localparam logic [1:0] RECHG_943_PML = 2'h1;
	localparam logic [1:0] RECHG_952_PML = 2'h2;
	localparam logic [1:0] RECHG_976_PML = 2'h3;

	// watchdog timeout select and limits in seconds
	localparam logic [1:0] WD_OFF    = 2'h0;
	localparam logic [1:0] WD_SEL_40 = 2'h1;
	localparam logic [1:0] WD_SEL_80 = 2'h2;
	localparam logic [7:0] WD_40_S   = 8'h28;
	localparam logic [7:0] WD_80_S   = 8'h50;
	localparam logic [7:0] WD_160_S  = 8'hA0;

	// one watchdog tick is one second
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned WD_TICK_NS     = 1000000000;
	localparam int unsigned WD_TICK_CYCLES = WD_TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned WD_PRE_W       = 27;

	// serial bit counter value when a whole byte has been clocked
	localparam logic [3:0] BYTE_BITS = 4'h8;

	typedef struct packed {
		logic [1:0] recharge_threshold_sel;
		logic       watchdog_kick;
		logic       charge_pin_disable;
		logic       charge_enable_expiry_value;
		logic       high_impedance_enable;
		logic       battery_sink_enable;
		logic       charge_enable;
	} ccpr_ctrl_t;

	typedef struct packed {
		logic charge_current_pin_enable;
		logic input_limit_pin_enable;
		logic power_good_pin_disable;
		logic status_pins_disable;
		logic force_out4_low;
		logic force_out3_low;
		logic force_out2_low;
		logic force_out1_low;
	} ccpr_pin_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic [7:0] data;
	} ccpr_wr_t;

	function automatic logic [7:0] ccpr_read(input logic [7:0] a, input ccpr_ctrl_t c,
		input ccpr_pin_t p);
		case (a)
			CTRL_OFFSET: return c;
			PIN_OFFSET:  return p;
			default:     return UNMAPPED_RD;
		endcase
	endfunction

	function automatic logic [7:0] ccpr_wd_limit(input logic [1:0] sel);
		case (sel)
			WD_SEL_40: return WD_40_S;
			WD_SEL_80: return WD_80_S;
			default:   return WD_160_S;
		endcase
	endfunction

endpackage

// ===== src/ccpr_sync.sv
// two-flop synchronisers for pad inputs
`timescale 1ns/1ns
module ccpr_sync
	import ccpr_pkg::*;
#(
	parameter int unsigned W = 4
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] async_in,
	output logic [W-1:0]      sync_q
);

	logic [W-1:0] meta_q;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (reset) begin
					meta_q[i] <= 1'b1;
					sync_q[i] <= 1'b1;
				end else begin
					meta_q[i] <= async_in[i];
					sync_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate

endmodule // ccpr_sync

// ===== src/ccpr_watchdog.sv
// host watchdog: one-second prescaler and selectable timeout
`timescale 1ns/1ns
module ccpr_watchdog
	import ccpr_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = WD_TICK_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [1:0] timeout_sel,
	input  wire logic       kick,
	output logic            expire_q
);

	logic [WD_PRE_W-1:0] pre_q;
	logic [WD_PRE_W-1:0] pre_d;
	logic [7:0]          sec_q;
	logic [7:0]          sec_d;
	logic                expire_d;

	always_comb begin
		pre_d    = pre_q;
		sec_d    = sec_q;
		expire_d = 1'b0;
		if (kick || timeout_sel == WD_OFF) begin // R16
			pre_d = '0;
			sec_d = '0;
		end else if (pre_q == WD_PRE_W'(TICK_CYCLES - 1)) begin
			pre_d = '0;
			if (sec_q >= ccpr_wd_limit(timeout_sel) - 8'h01) begin // R16
				sec_d    = '0;
				expire_d = 1'b1;
			end else begin
				sec_d = sec_q + 8'h01;
			end
		end else begin
			pre_d = pre_q + WD_PRE_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pre_q    <= '0;
			sec_q    <= '0;
			expire_q <= 1'b0;
		end else begin
			pre_q    <= pre_d;
			sec_q    <= sec_d;
			expire_q <= expire_d;
		end
	end

	property p_wd_off_quiet;
		@(posedge clk) disable iff (reset)
		timeout_sel == WD_OFF |=> !expire_q;
	endproperty
	a_wd_off_quiet: assert property (p_wd_off_quiet) else $error("watchdog fired while off"); // R16

	property p_wd_kick_restart;
		@(posedge clk) disable iff (reset)
		kick |=> !expire_q ##1 (sec_q == 8'h00);
	endproperty
	a_wd_kick_restart: assert property (p_wd_kick_restart) else $error("kick did not restart"); // R16

endmodule // ccpr_watchdog

// ===== src/ccpr_regs.sv
// charger control and pin control registers behind a serial target port
// What this block does
// (R1) Bits 7:6 pick recharge threshold, reset 11b
// (R2) Kick bit restarts watchdog, then self-clears
// (R3) Charge pin disable makes block ignore pin
// (R4) Watchdog expiry loads charge enable from bit3
// (R5) Sink enable drives battery sink; expiry clears
// (R6) Host should stop battery current conversion meanwhile
// (R7) Charge current pin enable, reset-only, default one
// (R8) Input limit pin enable restored on expiry
// (R9) Power-good pin disable stops normal power-good output
// (R10) Status pins disable stops normal status outputs
// (R11) Force out4 low only when pin disabled
// (R12) Force out3 low only when power-good disabled
// (R13) Force out2 low only when status disabled
// (R14) Force out1 low only when status disabled
// (R15) High impedance clears on reset, expiry, adapter
// (R16) Watchdog times out after 40/80/160 s
`timescale 1ns/1ns
module ccpr_regs
	import ccpr_pkg::*;
#(
	parameter logic [6:0]  DEV_ADDR    = 7'h55,
	parameter int unsigned TICK_CYCLES = WD_TICK_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       scl,
	input  wire logic       sda_level,
	output logic            sda_value_q,
	output logic            sda_oe_n_q,
	input  wire logic [1:0] wd_timeout_sel,
	input  wire logic       reg_reset_req,
	input  wire logic       adapter_present,
	input  wire logic [1:0] charger_status,
	input  wire logic       power_good,
	input  wire logic       ce_pin_level,
	output logic [3:0]      od_pin_value_q,
	output logic [3:0]      od_pin_oe_n_q,
	output logic            charge_active_q,
	output logic [1:0]      recharge_threshold_sel_q,
	output logic            high_impedance_q,
	output logic            battery_sink_q,
	output logic            charge_current_pin_en_q,
	output logic            input_limit_pin_en_q
);

	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK,
		S_WR, S_WR_ACK, S_RD, S_RD_ACK
	} ccpr_state_t;

	logic [3:0]  sync_q;
	logic        scl_s;
	logic        sda_s;
	logic        ce_n_s;
	logic        adapter_s;
	logic        scl_p_q;
	logic        sda_p_q;
	logic        adapter_p_q;
	logic        scl_rise;
	logic        scl_fall;
	logic        bus_start;
	logic        bus_stop;
	logic        adapter_rise;
	logic        wd_expire;

	ccpr_state_t st_q;
	ccpr_state_t st_d;
	logic [3:0]  cnt_q;
	logic [3:0]  cnt_d;
	logic [7:0]  shift_q;
	logic [7:0]  shift_d;
	logic [7:0]  ptr_q;
	logic [7:0]  ptr_d;
	logic        rw_q;
	logic        rw_d;
	logic        nack_q;
	logic        nack_d;
	logic        oe_n_d;
	ccpr_wr_t    wr_q;
	ccpr_wr_t    wr_d;

	ccpr_ctrl_t  ctrl_q;
	ccpr_ctrl_t  ctrl_d;
	ccpr_pin_t   pin_q;
	ccpr_pin_t   pin_d;
	logic [3:0]  od_oe_n_d;
	logic        charge_active_d;

	ccpr_sync #(
		.W (4)
	) u_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in ({adapter_present, ce_pin_level, sda_level, scl}),
		.sync_q   (sync_q)
	);

	assign scl_s     = sync_q[0];
	assign sda_s     = sync_q[1];
	assign ce_n_s    = sync_q[2];
	assign adapter_s = sync_q[3];

	assign scl_rise     = scl_s & ~scl_p_q;
	assign scl_fall     = ~scl_s & scl_p_q;
	assign bus_start    = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign bus_stop     = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign adapter_rise = adapter_s & ~adapter_p_q;

	// the watchdog restart is the cycle the kick bit stands
	ccpr_watchdog #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_wd (
		.clk         (clk),
		.reset       (reset),
		.timeout_sel (wd_timeout_sel),
		.kick        (ctrl_q.watchdog_kick),
		.expire_q    (wd_expire)
	);

	// serial target: address, pointer byte, data with auto-increment
	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		shift_d = shift_q;
		ptr_d   = ptr_q;
		rw_d    = rw_q;
		nack_d  = nack_q;
		oe_n_d  = sda_oe_n_q;
		wr_d    = '0;
		if (bus_start) begin
			st_d   = S_ADDR;
			cnt_d  = '0;
			oe_n_d = 1'b1;
		end else if (bus_stop) begin
			st_d   = S_IDLE;
			oe_n_d = 1'b1;
		end else if (scl_rise) begin
			case (st_q)
				S_ADDR, S_PTR, S_WR: begin
					shift_d = {shift_q[6:0], sda_s};
					cnt_d   = cnt_q + 4'h1;
				end
				S_RD: cnt_d = cnt_q + 4'h1;
				S_RD_ACK: nack_d = sda_s;
				default: ;
			endcase
		end else if (scl_fall) begin
			case (st_q)
				S_ADDR: begin
					if (cnt_q == BYTE_BITS) begin
						if (shift_q[7:1] == DEV_ADDR) begin
							st_d   = S_ADDR_ACK;
							rw_d   = shift_q[0];
							oe_n_d = 1'b0;
						end else begin
							st_d = S_IDLE;
						end
					end
				end
				S_ADDR_ACK: begin
					cnt_d = '0;
					if (rw_q) begin
						st_d    = S_RD;
						shift_d = ccpr_read(ptr_q, ctrl_q, pin_q);
						oe_n_d  = shift_d[7];
					end else begin
						st_d   = S_PTR;
						oe_n_d = 1'b1;
					end
				end
				S_PTR: begin
					if (cnt_q == BYTE_BITS) begin
						st_d   = S_PTR_ACK;
						ptr_d  = shift_q;
						oe_n_d = 1'b0;
					end
				end
				S_WR: begin
					if (cnt_q == BYTE_BITS) begin
						st_d   = S_WR_ACK;
						wr_d   = '{valid: 1'b1, addr: ptr_q, data: shift_q};
						ptr_d  = ptr_q + 8'h01;
						oe_n_d = 1'b0;
					end
				end
				S_PTR_ACK, S_WR_ACK: begin
					st_d   = S_WR;
					cnt_d  = '0;
					oe_n_d = 1'b1;
				end
				S_RD: begin
					if (cnt_q == BYTE_BITS) begin
						st_d   = S_RD_ACK;
						ptr_d  = ptr_q + 8'h01;
						oe_n_d = 1'b1;
					end else begin
						shift_d = {shift_q[6:0], 1'b0};
						oe_n_d  = shift_q[6];
					end
				end
				S_RD_ACK: begin
					if (nack_q) begin
						st_d   = S_IDLE;
						oe_n_d = 1'b1;
					end else begin
						st_d    = S_RD;
						cnt_d   = '0;
						shift_d = ccpr_read(ptr_q, ctrl_q, pin_q);
						oe_n_d  = shift_d[7];
					end
				end
				default: st_d = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_q        <= S_IDLE;
			cnt_q       <= '0;
			shift_q     <= '0;
			ptr_q       <= '0;
			rw_q        <= 1'b0;
			nack_q      <= 1'b1;
			wr_q        <= '0;
			sda_oe_n_q  <= 1'b1;
			sda_value_q <= 1'b0;
			scl_p_q     <= 1'b1;
			sda_p_q     <= 1'b1;
			adapter_p_q <= 1'b1;
		end else begin
			st_q        <= st_d;
			cnt_q       <= cnt_d;
			shift_q     <= shift_d;
			ptr_q       <= ptr_d;
			rw_q        <= rw_d;
			nack_q      <= nack_d;
			wr_q        <= wr_d;
			sda_oe_n_q  <= oe_n_d;
			sda_value_q <= 1'b0;
			scl_p_q     <= scl_s;
			sda_p_q     <= sda_s;
			adapter_p_q <= adapter_s;
		end
	end

	// register file: host writes, then event resets, register reset last
	always_comb begin
		ccpr_ctrl_t w;
		w      = ccpr_ctrl_t'(wr_q.data);
		ctrl_d = ctrl_q;
		pin_d  = pin_q;
		ctrl_d.watchdog_kick = 1'b0; // R2
		if (wr_q.valid && wr_q.addr == CTRL_OFFSET) begin
			ctrl_d               = w; // R1
			ctrl_d.watchdog_kick = w.watchdog_kick; // R2
		end
		if (wr_q.valid && wr_q.addr == PIN_OFFSET) begin
			pin_d = ccpr_pin_t'(wr_q.data);
		end
		if (wd_expire) begin
			ctrl_d.charge_enable          = ctrl_d.charge_enable_expiry_value; // R4
			ctrl_d.high_impedance_enable  = 1'b0; // R15
			ctrl_d.battery_sink_enable    = 1'b0; // R5
			pin_d.input_limit_pin_enable  = 1'b1; // R8
		end
		if (adapter_rise) begin
			ctrl_d.high_impedance_enable = 1'b0; // R15
		end
		if (reg_reset_req) begin
			ctrl_d = ccpr_ctrl_t'(CTRL_RESET); // R1 R15
			pin_d  = ccpr_pin_t'(PIN_RESET); // R7
		end
	end

	// pad drive: low enable pulls the open-drain pin low
	always_comb begin
		od_oe_n_d[0] = pin_q.status_pins_disable ? ~pin_q.force_out1_low
			: ~charger_status[0]; // R10 R14
		od_oe_n_d[1] = pin_q.status_pins_disable ? ~pin_q.force_out2_low
			: ~charger_status[1]; // R10 R13
		od_oe_n_d[2] = pin_q.power_good_pin_disable ? ~pin_q.force_out3_low
			: ~power_good; // R9 R12
		od_oe_n_d[3] = ctrl_q.charge_pin_disable ? ~pin_q.force_out4_low : 1'b1; // R11
		charge_active_d = ctrl_q.charge_enable & (ctrl_q.charge_pin_disable | ~ce_n_s); // R3
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_q          <= ccpr_ctrl_t'(CTRL_RESET);
			pin_q           <= ccpr_pin_t'(PIN_RESET);
			od_pin_oe_n_q   <= 4'hF;
			od_pin_value_q  <= 4'h0;
			charge_active_q <= 1'b0;
		end else begin
			ctrl_q          <= ctrl_d;
			pin_q           <= pin_d;
			od_pin_oe_n_q   <= od_oe_n_d;
			od_pin_value_q  <= 4'h0;
			charge_active_q <= charge_active_d;
		end
	end

	assign recharge_threshold_sel_q = ctrl_q.recharge_threshold_sel; // R1
	assign high_impedance_q         = ctrl_q.high_impedance_enable;
	assign battery_sink_q           = ctrl_q.battery_sink_enable; // R5
	assign charge_current_pin_en_q  = pin_q.charge_current_pin_enable; // R7
	assign input_limit_pin_en_q     = pin_q.input_limit_pin_enable; // R8

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_kick_write;
		wr_q.valid && wr_q.addr == CTRL_OFFSET && wr_q.data[5] && !reg_reset_req;
	endsequence
	sequence s_kick_served;
		ctrl_q.watchdog_kick ##1 !ctrl_q.watchdog_kick;
	endsequence

	property p_kick;
		s_kick_write |=> s_kick_served;
	endproperty
	a_kick: assert property (p_kick) else $error("kick bit not one-cycle"); // R2

	property p_reg_reset;
		reg_reset_req |=> recharge_threshold_sel_q == RECHG_976_PML && ctrl_q.charge_enable
			&& pin_q == ccpr_pin_t'(PIN_RESET);
	endproperty
	a_reg_reset: assert property (p_reg_reset) else $error("register reset wrong"); // R1

	property p_charge_gate;
		1 |=> charge_active_q == $past(ctrl_q.charge_enable
			&& (ctrl_q.charge_pin_disable || !ce_n_s));
	endproperty
	a_charge_gate: assert property (p_charge_gate) else $error("charge pin gating wrong"); // R3

	property p_expiry_charge;
		wd_expire && !wr_q.valid && !reg_reset_req
			|=> ctrl_q.charge_enable == $past(ctrl_q.charge_enable_expiry_value)
			&& !battery_sink_q && !high_impedance_q && input_limit_pin_en_q;
	endproperty
	a_expiry_charge: assert property (p_expiry_charge) else $error("expiry reload wrong"); // R4

	property p_sink_cleared;
		wd_expire |=> !battery_sink_q;
	endproperty
	a_sink_cleared: assert property (p_sink_cleared) else $error("sink survived expiry"); // R5

	property p_charge_current_set_pin_pin_kept;
		wd_expire && !wr_q.valid && !reg_reset_req |=> $stable(charge_current_pin_en_q);
	endproperty
	a_charge_current_set_pin_pin_kept: assert property (p_charge_current_set_pin_pin_kept) else $error("charge_current_set_pin bit hit by expiry"); // R7

	property p_ilim_restore;
		wd_expire |=> input_limit_pin_en_q;
	endproperty
	a_ilim_restore: assert property (p_ilim_restore) else $error("ilim not restored"); // R8

	property p_out3;
		1 |=> od_pin_oe_n_q[2] == $past(pin_q.power_good_pin_disable
			? !pin_q.force_out3_low : !power_good);
	endproperty
	a_out3: assert property (p_out3) else $error("out3 drive wrong"); // R9

	property p_status_pins;
		1 |=> od_pin_oe_n_q[1:0] == $past(pin_q.status_pins_disable
			? ~{pin_q.force_out2_low, pin_q.force_out1_low} : ~charger_status);
	endproperty
	a_status_pins: assert property (p_status_pins) else $error("out1/out2 drive wrong"); // R10

	property p_out4;
		!ctrl_q.charge_pin_disable |=> od_pin_oe_n_q[3];
	endproperty
	a_out4: assert property (p_out4) else $error("out4 driven while pin active"); // R11

	property p_hiz_clear;
		adapter_rise || wd_expire || reg_reset_req |=> !high_impedance_q;
	endproperty
	a_hiz_clear: assert property (p_hiz_clear) else $error("hiz not cleared"); // R15

endmodule // ccpr_regs

// ===== test/ccpr_host_model.sv
// serial host model that programs the charger registers over scl and sda
`timescale 1ns/1ns
module ccpr_host_model
	import ccpr_pkg::*;
#(
	parameter logic [6:0] ADDR = 7'h55
) (
	input  wire logic clk,
	input  wire logic sda_level,
	output logic      scl,
	output logic      sda_pull
);
	logic conv_off;

	initial begin
		scl      = 1'b1;
		sda_pull = 1'b0;
		conv_off = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask

	// one bit: data set mid low phase, sampled mid high phase
	task automatic put_bit(input logic b, output logic seen);
		wait_clk(6);
		sda_pull = ~b;
		wait_clk(6);
		scl = 1'b1;
		wait_clk(6);
		seen = sda_level;
		wait_clk(6);
		scl = 1'b0;
	endtask

	// start or repeated start
	task automatic start();
		wait_clk(6);
		sda_pull = 1'b0;
		wait_clk(6);
		scl = 1'b1;
		wait_clk(12);
		sda_pull = 1'b1;
		wait_clk(12);
		scl = 1'b0;
	endtask

	task automatic stop();
		wait_clk(6);
		sda_pull = 1'b1;
		wait_clk(6);
		scl = 1'b1;
		wait_clk(12);
		sda_pull = 1'b0;
		wait_clk(12);
	endtask

	// byte msb first, then the ninth bit; ack is low on the wire
	task automatic xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
		output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(tx[i], rx[i]);
		end
		put_bit(nine, s);
		ack = ~s;
	endtask

	task automatic probe(input logic [7:0] b, output logic ok);
		logic [7:0] rx;
		start();
		xfer(b, 1'b1, rx, ok);
		stop();
	endtask

	task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data, output logic ok);
		logic [7:0] rx;
		logic       a0;
		logic       a1;
		logic       a2;
		if (ptr == CTRL_OFFSET && data[1]) conv_off = 1'b1;
		start();
		xfer({ADDR, 1'b0}, 1'b1, rx, a0);
		xfer(ptr, 1'b1, rx, a1);
		xfer(data, 1'b1, rx, a2);
		stop();
		if (ptr == CTRL_OFFSET && !data[1]) conv_off = 1'b0;
		ok = a0 & a1 & a2;
	endtask

	task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data, output logic ok);
		logic [7:0] rx;
		logic       a0;
		logic       a1;
		logic       a2;
		logic       nk;
		start();
		xfer({ADDR, 1'b0}, 1'b1, rx, a0);
		xfer(ptr, 1'b1, rx, a1);
		start();
		xfer({ADDR, 1'b1}, 1'b1, rx, a2);
		xfer(8'hFF, 1'b1, data, nk);
		stop();
		ok = a0 & a1 & a2;
	endtask
endmodule // ccpr_host_model

// ===== test/charger_and_pin_control_regs_test.sv
// self-checking bench of the charger and pin control registers
`timescale 1ns/1ns
module charger_and_pin_control_regs_test;
	import ccpr_pkg::*;

	localparam int unsigned TICK = 50;

	logic       clk;
	logic       reset;
	logic       scl;
	logic       sda_pull;
	logic       sda_level;
	logic       sda_value_q;
	logic       sda_oe_n_q;
	logic [1:0] wd_timeout_sel;
	logic       reg_reset_req;
	logic       adapter_present;
	logic [1:0] charger_status;
	logic       power_good;
	logic       ce_ext;
	logic       ce_pin_level;
	logic [3:0] od_pin_value_q;
	logic [3:0] od_pin_oe_n_q;
	logic       charge_active_q;
	logic [1:0] recharge_threshold_sel_q;
	logic       high_impedance_q;
	logic       battery_sink_q;
	logic       charge_current_pin_en_q;
	logic       input_limit_pin_en_q;
	logic       ok;
	logic       cpd;
	logic [7:0] d;
	int         seed;
	int         bad_count;
	int         num_checks;

	// open-drain wires with pull-ups
	assign sda_level    = ~(sda_pull | ~sda_oe_n_q);
	assign ce_pin_level = ~(ce_ext | ~od_pin_oe_n_q[3]);

	ccpr_host_model host (
		.clk      (clk),
		.sda_level(sda_level),
		.scl      (scl),
		.sda_pull (sda_pull)
	);

	ccpr_regs #(.TICK_CYCLES(TICK)) dut (
		.clk                     (clk),
		.reset                   (reset),
		.scl                     (scl),
		.sda_level               (sda_level),
		.sda_value_q             (sda_value_q),
		.sda_oe_n_q              (sda_oe_n_q),
		.wd_timeout_sel          (wd_timeout_sel),
		.reg_reset_req           (reg_reset_req),
		.adapter_present         (adapter_present),
		.charger_status          (charger_status),
		.power_good              (power_good),
		.ce_pin_level            (ce_pin_level),
		.od_pin_value_q          (od_pin_value_q),
		.od_pin_oe_n_q           (od_pin_oe_n_q),
		.charge_active_q         (charge_active_q),
		.recharge_threshold_sel_q(recharge_threshold_sel_q),
		.high_impedance_q        (high_impedance_q),
		.battery_sink_q          (battery_sink_q),
		.charge_current_pin_en_q (charge_current_pin_en_q),
		.input_limit_pin_en_q    (input_limit_pin_en_q)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
		logic a;
		host.write_reg(ptr, data, a);
		check(a, 8'h01);
	endtask

	task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
		logic [7:0] v;
		logic       a;
		host.read_reg(ptr, v, a);
		check(a, 8'h01);
		check(v, exp);
	endtask

	// expected pad enables: low means pulled low
	function automatic logic [3:0] exp_oe(input ccpr_pin_t p, input logic c,
		input logic [1:0] cs, input logic pg);
		exp_oe[0] = p.status_pins_disable ? ~p.force_out1_low : ~cs[0];
		exp_oe[1] = p.status_pins_disable ? ~p.force_out2_low : ~cs[1];
		exp_oe[2] = p.power_good_pin_disable ? ~p.force_out3_low : ~pg;
		exp_oe[3] = ~(c & p.force_out4_low);
	endfunction

	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		test_done();
	end

	initial begin
		seed            = 32'h9E22;
		bad_count       = 0;
		num_checks      = 0;
		reset           = 1'b1;
		wd_timeout_sel  = WD_OFF;
		reg_reset_req   = 1'b0;
		adapter_present = 1'b0;
		charger_status  = 2'h0;
		power_good      = 1'b0;
		ce_ext          = 1'b0;
		repeat (20) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
		check(recharge_threshold_sel_q, 8'h03);
		check({high_impedance_q, battery_sink_q}, 8'h00);
		check({charge_current_pin_en_q, input_limit_pin_en_q}, 8'h03);
		check(od_pin_oe_n_q, 8'h0F);
		check(charge_active_q, 8'h00);
		rd_chk(CTRL_OFFSET, CTRL_RESET);
		rd_chk(PIN_OFFSET, PIN_RESET);
		rd_chk(8'h20, UNMAPPED_RD);
		host.probe({7'h2A, 1'b0}, ok);
		check(ok, 8'h00);
		for (int i = 0; i < 4; i++) begin
			d = {i[1:0], 1'b0, 5'($random(seed))};
			wr(CTRL_OFFSET, d);
			check(recharge_threshold_sel_q, d[7:6]);
			check({high_impedance_q, battery_sink_q}, d[2:1]);
			rd_chk(CTRL_OFFSET, d);
		end
		wr(CTRL_OFFSET, 8'hE9);
		rd_chk(CTRL_OFFSET, 8'hC9);
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'hDF : 8'($random(seed));
			cpd = i[0];
			{charger_status, power_good, ce_ext} = 4'($random(seed));
			wr(CTRL_OFFSET, {3'b110, cpd, 4'b1001});
			wr(PIN_OFFSET, d);
			check(od_pin_oe_n_q, exp_oe(d, cpd, charger_status, power_good));
			check({sda_value_q, od_pin_value_q}, 8'h00);
			check(charge_active_q, cpd | ce_ext);
			check({charge_current_pin_en_q, input_limit_pin_en_q}, d[7:6]);
		end
		wr(PIN_OFFSET, 8'h00);
		wr(CTRL_OFFSET, 8'hD7);
		wd_timeout_sel = WD_SEL_40;
		wr(CTRL_OFFSET, 8'hF7);
		repeat (1500) @(negedge clk);
		check({high_impedance_q, battery_sink_q, charge_active_q}, 8'h07);
		repeat (600) @(negedge clk);
		check({high_impedance_q, battery_sink_q, charge_active_q}, 8'h00);
		check({charge_current_pin_en_q, input_limit_pin_en_q}, 8'h01);
		wd_timeout_sel = WD_OFF;
		rd_chk(CTRL_OFFSET, 8'hD0);
		rd_chk(PIN_OFFSET, 8'h40);
		reg_reset_req = 1'b1;
		@(negedge clk);
		reg_reset_req = 1'b0;
		rd_chk(CTRL_OFFSET, CTRL_RESET);
		rd_chk(PIN_OFFSET, PIN_RESET);
		wr(CTRL_OFFSET, 8'hC7);
		adapter_present = 1'b1;
		repeat (6) @(negedge clk);
		check({high_impedance_q, battery_sink_q}, 8'h01);
		// 80 s select: sink survives just short of the limit, clears after
		wd_timeout_sel = WD_SEL_80;
		wr(CTRL_OFFSET, 8'hE3);
		repeat (3800) @(negedge clk);
		check(battery_sink_q, 8'h01);
		repeat (400) @(negedge clk);
		check(battery_sink_q, 8'h00);
		wd_timeout_sel = WD_OFF;
		test_done();
	end
endmodule // charger_and_pin_control_regs_test
